// ---- logic/bsp_sram_dev.sv ----
// memory device end: command state machines, write buffer, array, read pipe
`default_nettype none
// Functional notes
// [R1] second beat addresses base plus one
// [R2] low read select at true edge reads
// [R3] low write select at true edge writes
// [R4] read and write machines run independently
// [R5] machines advance on true edges only
// [R6] drain before stop; hold state while stopped
// [R7] read beats at t+2.5 and t+3.0
// [R8] controller gives write beats at t, t+0.5
// [R9] same command on next edge ignored
// [R10] both selects after idle: write ignored
// [R11] narrow width: two lane masks per beat
// [R12] wide width: four lane masks per beat
// [R13] masks belong to the issued write only
// [R14] reads see data still in write buffer
// [R15] valid flag leads first, drops before last
// [R16] bypass mode gives one cycle latency
// [R17] no request: read data high impedance
module bsp_sram_dev
  import bsp_pkg::*;
(
  input  wire logic   clk,      // system clock, 100 MHz
  input  wire logic   nrst,     // synchronous reset, active low
  bsp_link_if.dev     lnk,      // link pins
  output var  logic   dev_busy  // a read or write is in flight
);
  logic edge_t;
  logic edge_c;
  logic rd_take;
  logic wr_take;
  logic beat0;
  logic beat1;
  logic flag_next;
  int   lat;

  logic      rd_busy_reg;
  logic      wr_busy_reg;
  logic      nop_prev_reg;
  logic      rd_pipe_reg [PIPE_D];
  bsp_addr_t rd_padr_reg [PIPE_D];
  logic      w_pend_reg;
  bsp_addr_t w_addr_reg;
  bsp_data_t w_d0_reg;
  bsp_mask_t w_m0_reg;
  logic      wb_valid_reg;
  bsp_addr_t wb_addr_reg;
  bsp_data_t wb_d_reg [2];
  bsp_mask_t wb_m_reg [2];
  bsp_data_t rdata_reg;
  logic      roe_reg;
  logic      flag_reg;
  logic      echo_reg;
  bsp_data_t mem [2 ** (AW + 1)];

  // every register below except dev_busy moves only on link edges, so a stopped clock freezes them
  assign edge_t = lnk.clock_run & lnk.input_timing_true; // [R5]
  assign edge_c = lnk.clock_run & ~lnk.input_timing_true;

  // command acceptance; second request on the next edge falls on a busy machine
  assign rd_take = edge_t & ~rd_busy_reg & ~lnk.read_select_n; // [R2] [R9]
  assign wr_take = edge_t & ~wr_busy_reg & ~lnk.write_select_n
                 & ~(rd_take & nop_prev_reg); // [R3] [R9] [R10]

  // read state machine
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rd_busy_reg <= 1'b0;
    end else if (edge_t) begin
      rd_busy_reg <= rd_take; // [R4] [R5]
    end
  end

  // write state machine, independent of the read one except for the read-wins tie break after an idle edge
  always_ff @(posedge clk) begin
    if (!nrst) begin
      wr_busy_reg <= 1'b0;
    end else if (edge_t) begin
      wr_busy_reg <= wr_take; // [R4] [R5]
    end
  end

  // remembers an idle edge for the read-wins tie break
  always_ff @(posedge clk) begin
    if (!nrst) begin
      nop_prev_reg <= 1'b1;
    end else if (edge_t) begin
      nop_prev_reg <= lnk.read_select_n & lnk.write_select_n; // [R10]
    end
  end

  // latency in half cycles; mode is sampled live, so change it only when idle
  assign lat       = lnk.loop_bypass_n ? LAT_NORM : LAT_BYP; // [R16]
  assign beat0     = rd_pipe_reg[lat - 1];
  assign beat1     = rd_pipe_reg[lat];
  assign flag_next = rd_pipe_reg[lat - 2];

  // read pipe: one slot per half cycle, up to two reads in flight
  always_ff @(posedge clk) begin
    if (!nrst) begin
      for (int i = 0; i < PIPE_D; i++) begin
        rd_pipe_reg[i] <= 1'b0;
        rd_padr_reg[i] <= '0;
      end
    end else if (lnk.clock_run) begin
      rd_pipe_reg[0] <= rd_take;
      rd_padr_reg[0] <= lnk.read_addr;
      for (int i = 1; i < PIPE_D; i++) begin
        rd_pipe_reg[i] <= rd_pipe_reg[i - 1];
        rd_padr_reg[i] <= rd_padr_reg[i - 1];
      end
    end
  end

  // write staging: first beat and its mask taken with the command
  always_ff @(posedge clk) begin
    if (!nrst) begin
      w_pend_reg <= 1'b0;
      w_addr_reg <= '0;
      w_d0_reg   <= '0;
      w_m0_reg   <= '1;
    end else if (wr_take) begin
      w_pend_reg <= 1'b1;
      w_addr_reg <= lnk.write_addr;
      w_d0_reg   <= lnk.write_data;        // [R8]
      w_m0_reg   <= lnk.lane_write_mask_n; // [R13]
    end else if (edge_c) begin
      w_pend_reg <= 1'b0;
    end
  end

  // write buffer: a burst waits here until the next write pushes it out
  always_ff @(posedge clk) begin
    if (!nrst) begin
      wb_valid_reg <= 1'b0;
      wb_addr_reg  <= '0;
      for (int b = 0; b < 2; b++) begin
        wb_d_reg[b] <= '0;
        wb_m_reg[b] <= '1;
      end
    end else if (edge_c && w_pend_reg) begin
      wb_valid_reg <= 1'b1;
      wb_addr_reg  <= w_addr_reg;
      wb_d_reg[0]  <= w_d0_reg;
      wb_m_reg[0]  <= w_m0_reg;
      wb_d_reg[1]  <= lnk.write_data;        // [R8]
      wb_m_reg[1]  <= lnk.lane_write_mask_n; // [R13]
    end
  end

  // array commit of the older burst; each lane gated by its own beat mask
  always_ff @(posedge clk) begin
    if (edge_c && w_pend_reg && wb_valid_reg) begin
      for (int b = 0; b < 2; b++) begin
        for (int l = 0; l < LANES; l++) begin
          if (!wb_m_reg[b][l]) begin // [R11] [R12]
            mem[{wb_addr_reg, b[0]}][l*LANE_W +: LANE_W] <= wb_d_reg[b][l*LANE_W +: LANE_W];
          end
        end
      end
    end
  end

  // array word overlaid lane by lane with the buffered burst
  function automatic bsp_data_t fetch(input bsp_addr_t a, input logic beat);
    bsp_data_t w;
    w = mem[{a, beat}]; // [R1]
    if (wb_valid_reg && wb_addr_reg == a) begin
      for (int l = 0; l < LANES; l++) begin
        if (!wb_m_reg[beat][l]) begin
          w[l*LANE_W +: LANE_W] = wb_d_reg[beat][l*LANE_W +: LANE_W]; // [R14]
        end
      end
    end
    return w;
  endfunction

  // read data output; undriven on any half cycle without a beat
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rdata_reg <= '0;
      roe_reg   <= 1'b0;
    end else if (lnk.clock_run) begin // [R6]
      roe_reg <= beat0 | beat1;       // [R17]
      if (beat0) begin
        rdata_reg <= fetch(rd_padr_reg[lat - 1], 1'b0); // [R7]
      end else if (beat1) begin
        rdata_reg <= fetch(rd_padr_reg[lat], 1'b1);     // [R1] [R7]
      end
    end
  end

  // valid flag runs half a cycle ahead of the beats
  always_ff @(posedge clk) begin
    if (!nrst) begin
      flag_reg <= 1'b0;
    end else if (lnk.clock_run) begin
      flag_reg <= flag_next; // [R15]
    end
  end

  // echo clock follows the input clock phase, aligned with data updates
  always_ff @(posedge clk) begin
    if (!nrst) begin
      echo_reg <= 1'b0;
    end else if (lnk.clock_run) begin
      echo_reg <= lnk.input_timing_true;
    end
  end

  // busy status for the user side
  always_ff @(posedge clk) begin
    if (!nrst) begin
      dev_busy <= 1'b0;
    end else begin
      dev_busy <= rd_busy_reg | wr_busy_reg | w_pend_reg | rd_take | wr_take
                | rd_pipe_reg[0] | rd_pipe_reg[1] | rd_pipe_reg[2]
                | rd_pipe_reg[3] | rd_pipe_reg[4] | rd_pipe_reg[5];
    end
  end

  assign lnk.read_data         = rdata_reg;
  assign lnk.read_data_oe      = roe_reg;
  assign lnk.output_valid_flag = flag_reg;
  assign lnk.echo_timing_true  = echo_reg;
endmodule
`default_nettype wire

// ---- logic/bsp_pkg.sv ----
// shared constants and types for the burst-of-two separate-I/O memory port
`default_nettype none
package bsp_pkg;
  // width option: 1 selects four 9-bit lanes, 0 selects two
  localparam bit WIDE_X36  = 1'b1;
  localparam int LANE_W    = 9;
  localparam int LANES     = WIDE_X36 ? 4 : 2;
  localparam int DW        = LANE_W * LANES;
  // burst address width; the beat bit below it makes the word index
  localparam int AW        = WIDE_X36 ? 19 : 20;
  // read latency in half cycles of the true clock (one clk each)
  localparam int LAT_NORM  = 5;
  localparam int LAT_BYP   = 2;
  localparam int PIPE_D    = LAT_NORM + 1;
  // controller waits this many clk after a command before stopping the clock
  localparam int DRAIN_CNT = PIPE_D + 2;
  localparam logic [3:0] DRAIN_INIT = 4'(DRAIN_CNT);
  typedef logic [DW-1:0]    bsp_data_t;
  typedef logic [LANES-1:0] bsp_mask_t;
  typedef logic [AW-1:0]    bsp_addr_t;
  typedef logic [AW:0]      bsp_word_t;
endpackage
`default_nettype wire

// ---- logic/bsp_link_if.sv ----
// pin-level link between memory controller and memory device
`default_nettype none
interface bsp_link_if;
  import bsp_pkg::*;
  logic      input_timing_true; // high: next edge is a true clock rise
  logic      clock_run;         // high: the link clock is running
  logic      read_select_n;     // read request, active low
  logic      write_select_n;    // write request, active low
  bsp_addr_t read_addr;         // read burst address
  bsp_addr_t write_addr;        // write burst address
  bsp_data_t write_data;        // double-rate write data
  bsp_mask_t lane_write_mask_n; // per-lane write enables, active low
  logic      loop_bypass_n;     // low: short-latency bypass mode
  bsp_data_t read_data;         // double-rate read data
  logic      read_data_oe;      // read data driven
  logic      output_valid_flag; // read data valid indicator
  logic      echo_timing_true;  // echo clock
  modport dev (
    input  input_timing_true, clock_run, read_select_n, write_select_n,
    input  read_addr, write_addr, write_data, lane_write_mask_n, loop_bypass_n,
    output read_data, read_data_oe, output_valid_flag, echo_timing_true
  );
  modport ctl (
    output input_timing_true, clock_run, read_select_n, write_select_n,
    output read_addr, write_addr, write_data, lane_write_mask_n, loop_bypass_n,
    input  read_data, read_data_oe, output_valid_flag, echo_timing_true
  );
endinterface
`default_nettype wire

// ---- logic/bsp_sram_ctl.sv ----
// memory controller end: clock generation, command slots, read capture
`default_nettype none
module bsp_sram_ctl
  import bsp_pkg::*;
(
  input  wire logic      clk,        // system clock, 100 MHz
  input  wire logic      nrst,       // synchronous reset, active low
  bsp_link_if.ctl        lnk,        // link pins
  input  wire logic      run,        // level: keep the link clock running
  input  wire logic      bypass_en,  // level: short-latency mode
  input  wire logic      rd_req,     // level: read wanted
  input  wire bsp_addr_t rd_addr,    // read burst address
  input  wire logic      wr_req,     // level: write wanted
  input  wire bsp_addr_t wr_addr,    // write burst address
  input  wire bsp_data_t wr_data0,   // first write beat
  input  wire bsp_data_t wr_data1,   // second write beat
  input  wire bsp_mask_t wr_mask0_n, // first beat lane masks, active low
  input  wire bsp_mask_t wr_mask1_n, // second beat lane masks, active low
  output var  logic      rd_taken,   // pulse: read launched
  output var  logic      wr_taken,   // pulse: write launched
  output var  bsp_data_t rd_data0,   // first returned beat
  output var  bsp_data_t rd_data1,   // second returned beat
  output var  logic      rd_done,    // pulse: both beats captured
  output var  logic      stopped     // link clock is stopped
);
  logic do_rd;
  logic do_wr;
  logic kt_rising;

  logic      kt_reg;
  logic      run_reg;
  logic      slot_reg;
  logic [3:0] drain_reg;
  logic      beat2_reg;
  bsp_data_t d1_hold_reg;
  bsp_mask_t m1_hold_reg;
  logic      rsel_n_reg;
  logic      wsel_n_reg;
  bsp_addr_t radr_reg;
  bsp_addr_t wadr_reg;
  bsp_data_t wdata_reg;
  bsp_mask_t wmask_reg;
  logic      byp_n_reg;
  logic      flag_d_reg;

  // reads use even true edges, writes odd ones: each port gets every other edge
  assign kt_rising = run_reg & run & ~kt_reg;
  assign do_rd     = kt_rising & ~slot_reg & rd_req; // [R2] [R9]
  assign do_wr     = kt_rising & slot_reg & wr_req;  // [R3] [R9] [R10]

  // link clock phase and run control; stops only after every burst has drained
  always_ff @(posedge clk) begin
    if (!nrst) begin
      kt_reg   <= 1'b0;
      run_reg  <= 1'b0;
      slot_reg <= 1'b0;
    end else if (run_reg) begin
      if (!run && drain_reg == 4'h0 && !kt_reg) begin
        run_reg <= 1'b0; // [R6]
      end else begin
        kt_reg <= ~kt_reg;
        if (!kt_reg) begin
          slot_reg <= ~slot_reg;
        end
      end
    end else if (run) begin
      run_reg <= 1'b1;
    end
  end

  // drain counter covers the longest read plus the output release
  always_ff @(posedge clk) begin
    if (!nrst) begin
      drain_reg <= 4'h0;
    end else if (do_rd || do_wr) begin
      drain_reg <= DRAIN_INIT; // [R6]
    end else if (drain_reg != 4'h0 && run_reg) begin
      drain_reg <= drain_reg - 4'h1;
    end
  end

  // command pins, driven for exactly one true-edge cycle
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rsel_n_reg <= 1'b1;
      wsel_n_reg <= 1'b1;
      radr_reg   <= '0;
      wadr_reg   <= '0;
      byp_n_reg  <= 1'b1;
    end else begin
      rsel_n_reg <= ~do_rd;
      wsel_n_reg <= ~do_wr; // [R13]
      byp_n_reg  <= ~bypass_en;
      if (do_rd) begin
        radr_reg <= rd_addr;
      end
      if (do_wr) begin
        wadr_reg <= wr_addr;
      end
    end
  end

  // write beats: first with the command, second on the following half cycle
  always_ff @(posedge clk) begin
    if (!nrst) begin
      beat2_reg   <= 1'b0;
      d1_hold_reg <= '0;
      m1_hold_reg <= '1;
      wdata_reg   <= '0;
      wmask_reg   <= '1;
    end else if (do_wr) begin
      beat2_reg   <= 1'b1;
      wdata_reg   <= wr_data0;   // [R8]
      wmask_reg   <= wr_mask0_n; // [R11] [R12]
      d1_hold_reg <= wr_data1;
      m1_hold_reg <= wr_mask1_n;
    end else if (beat2_reg) begin
      beat2_reg <= 1'b0;
      wdata_reg <= d1_hold_reg;  // [R8]
      wmask_reg <= m1_hold_reg;
    end else begin
      wmask_reg <= '1;           // idle beats write nothing
    end
  end

  // user handshake pulses and stopped status
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rd_taken <= 1'b0;
      wr_taken <= 1'b0;
      stopped  <= 1'b1;
    end else begin
      rd_taken <= do_rd;
      wr_taken <= do_wr;
      stopped  <= ~run_reg;
    end
  end

  // capture: flag seen last cycle marks the first beat, its absence the second
  always_ff @(posedge clk) begin
    if (!nrst) begin
      flag_d_reg <= 1'b0;
      rd_data0   <= '0;
      rd_data1   <= '0;
      rd_done    <= 1'b0;
    end else begin
      flag_d_reg <= lnk.output_valid_flag; // [R15]
      rd_done    <= lnk.read_data_oe & ~flag_d_reg & run_reg;
      if (lnk.read_data_oe && flag_d_reg) begin
        rd_data0 <= lnk.read_data;
      end
      if (lnk.read_data_oe && !flag_d_reg && run_reg) begin
        rd_data1 <= lnk.read_data;
      end
    end
  end

  assign lnk.input_timing_true = kt_reg;
  assign lnk.clock_run         = run_reg;
  assign lnk.read_select_n     = rsel_n_reg;
  assign lnk.write_select_n    = wsel_n_reg;
  assign lnk.read_addr         = radr_reg;
  assign lnk.write_addr        = wadr_reg;
  assign lnk.write_data        = wdata_reg;
  assign lnk.lane_write_mask_n = wmask_reg;
  assign lnk.loop_bypass_n     = byp_n_reg;
endmodule
`default_nettype wire

// ---- tb/bsp_link_sva.sv ----
// link assertions for the burst-of-two memory port
`default_nettype none
module bsp_link_sva
  import bsp_pkg::*;
(
  input wire logic      clk,               // system clock
  input wire logic      nrst,              // sync reset, low
  input wire logic      input_timing_true, // true edge phase
  input wire logic      clock_run,         // link clock runs
  input wire logic      read_select_n,     // read request
  input wire logic      loop_bypass_n,     // low: bypass
  input wire bsp_data_t read_data,         // read beats
  input wire logic      read_data_oe,      // read data driven
  input wire logic      output_valid_flag, // valid flag
  input wire logic      echo_timing_true   // echo phase
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // a read as the device takes it; reads come at most every 4 clk
  wire logic rd_cmd = clock_run && input_timing_true && !read_select_n;

  property p_rd_norm;
    rd_cmd && loop_bypass_n |-> ##5 output_valid_flag ##1 (read_data_oe && !output_valid_flag)
      ##1 read_data_oe ##1 !read_data_oe;
  endproperty
  a_rd_norm: assert property (p_rd_norm) else $error("normal read beats misplaced");
  property p_rd_byp;
    rd_cmd && !loop_bypass_n |-> ##2 output_valid_flag ##1 read_data_oe ##1 read_data_oe;
  endproperty
  a_rd_byp: assert property (p_rd_byp) else $error("bypass read beats misplaced");
  property p_oe_cause;
    $rose(read_data_oe) |-> ($past(rd_cmd, 6) && $past(loop_bypass_n, 6))
      || $past(rd_cmd, 3);
  endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("read data without a read");
  property p_oe_width;
    $rose(read_data_oe) |=> read_data_oe ##1 !read_data_oe;
  endproperty
  a_oe_width: assert property (p_oe_width) else $error("read data not released");
  property p_flag_lead;
    $rose(output_valid_flag) |=> !output_valid_flag && $rose(read_data_oe);
  endproperty
  a_flag_lead: assert property (p_flag_lead) else $error("valid flag not leading");
  property p_flag_cause;
    $rose(output_valid_flag) |-> $past(rd_cmd, 5) || $past(rd_cmd, 2);
  endproperty
  a_flag_cause: assert property (p_flag_cause) else $error("valid flag without read");
  property p_stop_hold;
    !clock_run |=> $stable(read_data) && $stable(read_data_oe)
      && $stable(output_valid_flag) && $stable(echo_timing_true);
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("outputs moved while stopped");
  property p_echo;
    clock_run |=> echo_timing_true == $past(input_timing_true);
  endproperty
  a_echo: assert property (p_echo) else $error("echo phase wrong");
endmodule
`default_nettype wire

// ---- tb/burst2_separate_io_sram_port_tb_top.sv ----
// self-checking bench: controller and device joined by the link
`default_nettype none
module burst2_separate_io_sram_port_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import bsp_pkg::*;
  localparam bsp_addr_t BASE = 19'h00100;
  logic      clk, nrst, run, bypass_en, rd_req, wr_req;
  logic      rd_taken, wr_taken, rd_done, stopped, dev_busy;
  bsp_addr_t rd_addr, wr_addr;
  bsp_data_t wr_data0, wr_data1, rd_data0, rd_data1;
  bsp_mask_t wr_mask0_n, wr_mask1_n;
  bsp_data_t mem [bsp_word_t]; // expected array contents
  int        n_fail, tests_run;
  bsp_link_if lnk ();
  bsp_sram_dev i_bsp_sram_dev (.clk(clk), .nrst(nrst), .lnk(lnk.dev), .dev_busy(dev_busy));
  bsp_sram_ctl i_bsp_sram_ctl (.clk(clk), .nrst(nrst), .lnk(lnk.ctl), .run(run),
    .bypass_en(bypass_en), .rd_req(rd_req), .rd_addr(rd_addr), .wr_req(wr_req),
    .wr_addr(wr_addr), .wr_data0(wr_data0), .wr_data1(wr_data1), .wr_mask0_n(wr_mask0_n),
    .wr_mask1_n(wr_mask1_n), .rd_taken(rd_taken), .wr_taken(wr_taken),
    .rd_data0(rd_data0), .rd_data1(rd_data1), .rd_done(rd_done), .stopped(stopped));
  bsp_link_sva i_bsp_link_sva (.clk(clk), .nrst(nrst),
    .input_timing_true(lnk.input_timing_true), .clock_run(lnk.clock_run),
    .read_select_n(lnk.read_select_n), .loop_bypass_n(lnk.loop_bypass_n),
    .read_data(lnk.read_data), .read_data_oe(lnk.read_data_oe),
    .output_valid_flag(lnk.output_valid_flag), .echo_timing_true(lnk.echo_timing_true));

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic ok, input string msg);
    tests_run++;
    if (ok !== 1'b1) begin
      n_fail++;
      $display("Error at %0t ns: %s", $time, msg);
    end
  endtask

  task automatic summarize();
    $display("Checks run: %0d, errors: %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // lanes whose mask bit is low take the new data
  function automatic bsp_data_t merge(bsp_data_t o, bsp_data_t d, bsp_mask_t m_n);
    for (int i = 0; i < LANES; i++)
      if (!m_n[i]) o[i*LANE_W +: LANE_W] = d[i*LANE_W +: LANE_W];
    return o;
  endfunction

  function automatic bsp_data_t rnd();
    return bsp_data_t'({$urandom(), $urandom()});
  endfunction

  // bounded wait, counting falling edges
  task automatic wait_hi(ref logic s, output int n);
    n = 0;
    while (s !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    if (n >= 40) chk(1'b0, "handshake timed out");
  endtask

  task automatic do_wr(bsp_addr_t a, bsp_data_t d0, d1, bsp_mask_t m0, m1);
    int n;
    @(negedge clk);
    {wr_addr, wr_data0, wr_data1, wr_mask0_n, wr_mask1_n, wr_req} = {a, d0, d1, m0, m1, 1'b1};
    wait_hi(wr_taken, n);
    wr_req = 1'b0;
    mem[{a, 1'b0}] = merge(mem[{a, 1'b0}], d0, m0);
    mem[{a, 1'b1}] = merge(mem[{a, 1'b1}], d1, m1);
  endtask

  task automatic do_rd(bsp_addr_t a);
    int n;
    @(negedge clk);
    rd_addr = a;
    rd_req = 1'b1;
    wait_hi(rd_taken, n);
    rd_req = 1'b0;
    wait_hi(rd_done, n);
    // done lags the latency by command flight, output register and capture
    chk(n == (bypass_en ? LAT_BYP + 3 : LAT_NORM + 3), "read latency");
    chk(rd_data0 === mem[{a, 1'b0}], "first beat");
    chk(rd_data1 === mem[{a, 1'b1}], "second beat");
  endtask

  // main sequence
  initial begin
    bsp_addr_t a;
    int        n;
    {nrst, run, bypass_en, rd_req, wr_req} = 5'h00;
    {rd_addr, wr_addr, wr_data0, wr_data1} = '0;
    {wr_mask0_n, wr_mask1_n} = '1;
    n_fail = 0;
    tests_run = 0;
    void'($urandom(34877));
    repeat (3) @(negedge clk);
    nrst = 1'b1;
    chk(lnk.read_data_oe === 1'b0 && stopped === 1'b1, "reset state");
    run = 1'b1;
    for (int i = 0; i < 8; i++) do_wr(bsp_addr_t'(BASE + i), rnd(), rnd(), '0, '0);
    // last write still sits in the buffer
    do_rd(bsp_addr_t'(BASE + 7));
    // first beat writes lane l only, second beat the other lanes; last pass aborts the first beat
    for (int l = 0; l <= LANES; l++) begin
      do_wr(BASE, rnd(), rnd(), ~(bsp_mask_t'(1) << l), bsp_mask_t'(1) << l);
      do_rd(BASE);
    end
    // random traffic, both ports busy together
    for (int k = 0; k < 40; k++) begin
      a = bsp_addr_t'(BASE + $urandom_range(7));
      fork
        do_wr(a, rnd(), rnd(), bsp_mask_t'($urandom), bsp_mask_t'($urandom));
        do_rd(a ^ 19'h00001);
      join
    end
    // latency mode only changes while idle
    bypass_en = 1'b1;
    repeat (4) @(negedge clk);
    for (int k = 0; k < 4; k++) do_rd(bsp_addr_t'(BASE + k));
    // the read pipe still shifts after done; a live mode change would misplace a beat
    repeat (4) @(negedge clk);
    bypass_en = 1'b0;
    // stop the link clock; contents must survive it
    run = 1'b0;
    wait_hi(stopped, n);
    chk(lnk.clock_run === 1'b0, "link clock still running");
    chk(dev_busy === 1'b0, "device busy while stopped");
    repeat (10) @(negedge clk);
    run = 1'b1;
    for (int k = 0; k < 8; k++) do_rd(bsp_addr_t'(BASE + k));
    summarize();
  end

  // watchdog, several times the expected run length
  initial begin
    #100000;
    n_fail++;
    summarize();
  end
endmodule
`default_nettype wire
